//--- rtl/pwdt_pkg.sv
package pwdt_pkg;
    // register addresses
    localparam logic [7:0] ADDR_RESTART = 8'ha6;
    localparam logic [7:0] ADDR_CONTROL = 8'ha7;
    // control register fields
    localparam int PS_HI = 7;
    localparam int PS_LO = 5;
    localparam int IDLE_FREEZE_BIT = 4;
    localparam int OVERFLOW_BIT = 1;
    localparam int RUNNING_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // key bytes
    localparam logic [7:0] KEY_FIRST = 8'h1e;
    localparam logic [7:0] KEY_SECOND = 8'he1;
    // counter structure
    localparam int PRESCALE_BITS = 7;
    localparam int COUNT_BITS = 14;
    localparam int PS_WIDTH = 3;
    // cycles of the reset pulse driven to the cpu
    localparam int RESET_PULSE_CYCLES = 4;
endpackage

//--- rtl/pwdt_if.sv
`timescale 1ns/100ps
// link between key checker and counter core
interface pwdt_if;
    logic feed;
    logic bad_key;
    modport checker_side (output feed, output bad_key);
    modport core_side (input feed, input bad_key);
endinterface

//--- rtl/pwdt_key_check.sv
`timescale 1ns/100ps
// two-byte key sequence checker on the register write port
module pwdt_key_check (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    pwdt_if.checker_side kp
);
    logic armed_q;
    logic key_hit;

    assign key_hit = wr_en && addr == pwdt_pkg::ADDR_RESTART;

    // first byte arms, second completes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
        end else if (wr_en) begin
            armed_q <= key_hit && !armed_q && wdata == pwdt_pkg::KEY_FIRST;
        end
    end

    // pulses toward the core
    always_comb begin
        kp.feed = key_hit && armed_q && wdata == pwdt_pkg::KEY_SECOND;
        kp.bad_key = 1'b0;
        if (key_hit && !armed_q && wdata != pwdt_pkg::KEY_FIRST) begin
            kp.bad_key = 1'b1;
        end else if (key_hit && armed_q && wdata != pwdt_pkg::KEY_SECOND) begin
            kp.bad_key = 1'b1;
        end else if (wr_en && !key_hit && armed_q) begin
            kp.bad_key = 1'b1;
        end
    end

    a_bad_first_key: assert property (@(posedge clk) disable iff (!reset_n)
        key_hit && !armed_q && wdata != pwdt_pkg::KEY_FIRST |-> kp.bad_key)
        else $error("wrong first key not flagged");
endmodule

//--- rtl/pwdt_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// How it works
// - timeout is 16K cycles doubled per period-select code, up to 2048K.
// - a 14-bit counter is clocked by a 7-bit programmable prescaler.
// - any reset disables the watchdog; power-down stops it.
// - an unserviced timeout emits an internal cpu reset pulse.
// - writing 1e then e1 to restart starts it; running flag reads 1.
// - a wrong key byte causes an immediate watchdog reset.
// - idle-freeze 0 keeps counting in idle; 1 holds the count.
// - overflow flag sets on any watchdog reset, survives it, software clears.
// - running flag is read-only and cleared by any reset.
// - restart register at a6 is write-only and only takes keys.
module pwdt_top #(
    parameter int PRESCALE_BITS = pwdt_pkg::PRESCALE_BITS,
    parameter int COUNT_BITS = pwdt_pkg::COUNT_BITS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic idle_mode,
    input wire logic power_down,
    output logic wdt_reset
);
    localparam int PULSE_W = 3;
    localparam logic [PULSE_W-1:0] PULSE_LEN =
        PULSE_W'(pwdt_pkg::RESET_PULSE_CYCLES);

    pwdt_if kp ();

    logic [pwdt_pkg::PS_WIDTH-1:0] period_sel_q;
    logic idle_freeze_q;
    logic overflow_flag_q;
    logic running_flag_q;
    logic [PRESCALE_BITS-1:0] prescale_q;
    logic [COUNT_BITS-1:0] count_q;
    logic [PULSE_W-1:0] pulse_q;
    logic [7:0] rdata_q;
    logic ctrl_wr;
    logic tick;
    logic advance;
    logic timeout;
    logic fire;

    // key byte checker
    pwdt_key_check u_key (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_en),
        .addr(addr),
        .wdata(wdata),
        .kp(kp)
    );

    // prescaler tap: 2^(code) prescale, so 16K << code total
    function automatic logic prescale_done(
        input logic [PRESCALE_BITS-1:0] pre,
        input logic [pwdt_pkg::PS_WIDTH-1:0] sel
    );
        logic [PRESCALE_BITS-1:0] mask;
        mask = PRESCALE_BITS'((1 << sel) - 1);
        prescale_done = (pre & mask) == mask;
    endfunction

    assign ctrl_wr = wr_en && addr == pwdt_pkg::ADDR_CONTROL;
    // counting allowed: running, not powered down, not frozen in idle
    assign advance = running_flag_q && !power_down
        && !(idle_mode && idle_freeze_q);
    assign tick = advance && prescale_done(prescale_q, period_sel_q);
    assign timeout = tick && (&count_q);
    assign fire = timeout || kp.bad_key;

    // control fields written by software
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            period_sel_q <= '0;
            idle_freeze_q <= 1'b0;
        end else if (ctrl_wr) begin
            period_sel_q <= wdata[pwdt_pkg::PS_HI:pwdt_pkg::PS_LO];
            idle_freeze_q <= wdata[pwdt_pkg::IDLE_FREEZE_BIT];
        end
    end

    // overflow flag: set wins over software clear
    // our own pulse goes to the cpu, not to reset_n, so the flag outlives it
    // an external reset_n clears it, which keeps power-on free of unknowns
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            overflow_flag_q <= 1'h0;
        end else if (fire) begin
            overflow_flag_q <= 1'b1;
        end else if (ctrl_wr) begin
            overflow_flag_q <= wdata[pwdt_pkg::OVERFLOW_BIT];
        end
    end

    // running flag, dropped by any reset including our own
    always_ff @(posedge clk) begin
        if (!reset_n || fire || pulse_q != '0) begin
            running_flag_q <= 1'b0;
        end else if (kp.feed) begin
            running_flag_q <= 1'b1;
        end
    end

    // prescaler and 14-bit counter
    always_ff @(posedge clk) begin
        if (!reset_n || kp.feed || !running_flag_q) begin
            prescale_q <= '0;
            count_q <= '0;
        end else if (advance) begin
            prescale_q <= tick ? '0 : prescale_q + 1'b1;
            if (tick) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // internal reset pulse toward the cpu
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pulse_q <= '0;
        end else if (fire) begin
            pulse_q <= PULSE_LEN;
        end else if (pulse_q != '0) begin
            pulse_q <= pulse_q - 1'b1;
        end
    end
    assign wdt_reset = pulse_q != '0;

    // read data; restart register reads as zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= pwdt_pkg::CONTROL_RESET;
        end else if (rd_en && addr == pwdt_pkg::ADDR_CONTROL) begin
            rdata_q <= {period_sel_q, idle_freeze_q, 2'b00,
                overflow_flag_q, running_flag_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata = rdata_q;


    // first key byte written while the checker is idle
    sequence s_arm;
        wr_en && addr == pwdt_pkg::ADDR_RESTART && wdata == pwdt_pkg::KEY_FIRST
            && !u_key.armed_q;
    endsequence

    // correct second key byte
    sequence s_key_two;
        wr_en && addr == pwdt_pkg::ADDR_RESTART && wdata == pwdt_pkg::KEY_SECOND;
    endsequence

    // wrong second key byte
    sequence s_key_wrong;
        wr_en && addr == pwdt_pkg::ADDR_RESTART && wdata != pwdt_pkg::KEY_SECOND;
    endsequence

    // a full reset pulse with no new fire event inside it
    sequence s_pulse;
        fire ##1 (wdt_reset && !fire) [*4];
    endsequence

    // feed sets the running flag
    a_feed_starts: assert property (@(posedge clk) disable iff (!reset_n)
        kp.feed && !fire |=> running_flag_q)
        else $error("feed did not set running flag");

    // pulse lasts the chosen length
    a_fire_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        fire |=> wdt_reset [*4])
        else $error("reset pulse too short");

    // pulse ends after its length
    a_pulse_ends: assert property (@(posedge clk) disable iff (!reset_n)
        s_pulse |=> !wdt_reset)
        else $error("reset pulse too long");

    // last tick of a full count fires
    a_count_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        tick && count_q == '1 |=> wdt_reset)
        else $error("timeout did not fire");

    // fire sets the overflow flag
    a_fire_flag: assert property (@(posedge clk) disable iff (!reset_n)
        fire |=> overflow_flag_q)
        else $error("overflow flag not set");

    // software clear takes effect when nothing fires
    a_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_wr && !wdata[pwdt_pkg::OVERFLOW_BIT] && !fire |=> !overflow_flag_q)
        else $error("overflow flag not cleared");

    // fire drops the running flag
    a_fire_stops: assert property (@(posedge clk) disable iff (!reset_n)
        fire |=> !running_flag_q)
        else $error("running flag survived reset");

    // system reset leaves everything idle
    a_reset_quiet: assert property (@(posedge clk)
        !reset_n |=> !running_flag_q && !wdt_reset && !overflow_flag_q)
        else $error("state survived system reset");

    // frozen idle holds the count
    a_freeze_hold: assert property (@(posedge clk) disable iff (!reset_n)
        idle_mode && idle_freeze_q && !kp.feed |=> $stable(count_q))
        else $error("count moved in frozen idle");

    // idle without freeze keeps counting
    a_idle_runs: assert property (@(posedge clk) disable iff (!reset_n)
        advance && idle_mode && !tick && !kp.feed
            |=> prescale_q == $past(prescale_q) + 1'h1)
        else $error("prescaler stopped in idle");

    // power-down holds the prescaler
    a_pd_hold: assert property (@(posedge clk) disable iff (!reset_n)
        power_down && running_flag_q && !kp.feed |=> $stable(prescale_q))
        else $error("prescaler moved in power-down");

    // power-down holds the counter
    a_pd_count: assert property (@(posedge clk) disable iff (!reset_n)
        power_down && running_flag_q && !kp.feed |=> $stable(count_q))
        else $error("counter moved in power-down");

    // feed restarts the count
    a_feed_clear: assert property (@(posedge clk) disable iff (!reset_n)
        kp.feed |=> count_q == '0 && prescale_q == '0)
        else $error("feed did not restart count");

    // two good key bytes with a quiet cycle between form a feed
    a_key_pair: assert property (@(posedge clk) disable iff (!reset_n)
        s_arm ##1 !wr_en ##1 s_key_two |-> kp.feed)
        else $error("key pair not accepted");

    // wrong second byte is punished
    a_bad_second: assert property (@(posedge clk) disable iff (!reset_n)
        s_arm ##1 !wr_en ##1 s_key_wrong |-> kp.bad_key)
        else $error("wrong second key not flagged");

    // bad key stops the watchdog
    a_bad_stops: assert property (@(posedge clk) disable iff (!reset_n)
        kp.bad_key |=> !running_flag_q && wdt_reset)
        else $error("bad key did not reset");

    // write between keys fires
    a_stray_write: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_wr && u_key.armed_q |=> wdt_reset)
        else $error("write between keys not punished");

    // write between keys sets the overflow flag
    a_stray_flag: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_wr && u_key.armed_q |=> overflow_flag_q)
        else $error("stray write left flag clear");

    // control writes load the period select
    a_ps_load: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_wr |=> period_sel_q == $past(wdata[pwdt_pkg::PS_HI:pwdt_pkg::PS_LO]))
        else $error("period select not loaded");

    // control read shows the running flag
    a_read_running: assert property (@(posedge clk) disable iff (!reset_n)
        rd_en && addr == pwdt_pkg::ADDR_CONTROL
            |=> rdata[pwdt_pkg::RUNNING_BIT] == $past(running_flag_q))
        else $error("running flag misread");

    // any other read returns zero
    a_restart_zero: assert property (@(posedge clk) disable iff (!reset_n)
        rd_en && addr != pwdt_pkg::ADDR_CONTROL |=> rdata == 8'h00)
        else $error("write-only register readable");
endmodule

//--- dv/test_programmable_watchdog_timer.sv
`timescale 1ns/100ps
module test_programmable_watchdog_timer;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic idle_mode = 1'b0;
    logic power_down = 1'b0;
    logic [7:0] rdata;
    logic wdt_reset;
    int miscompares = 0;
    int comparisons = 0;
    // short counter keeps timeouts at 16 << ps cycles
    pwdt_top #(.COUNT_BITS(4)) dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .idle_mode(idle_mode), .power_down(power_down), .wdt_reset(wdt_reset));
    // 25 mhz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write and read strobes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic key();
        wr(pwdt_pkg::ADDR_RESTART, pwdt_pkg::KEY_FIRST);
        wr(pwdt_pkg::ADDR_RESTART, pwdt_pkg::KEY_SECOND);
    endtask
    task automatic rst();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    // counts cycles to the reset pulse, holding idle or power-down for the first idl or pdl cycles
    task automatic fire(input int idl, input int pdl, input int exp);
        int n;
        int w;
        n = 0;
        w = 0;
        idle_mode <= (idl > 0);
        power_down <= (pdl > 0);
        #1;
        while (wdt_reset !== 1'b1 && n < 6000) begin
            @(posedge clk);
            n++;
            idle_mode <= (n < idl);
            power_down <= (n < pdl);
            #1;
        end
        chk("fire time", exp, (n + 2 >= exp && n <= exp + 2) ? exp : n);
        while (wdt_reset === 1'b1 && w < 9) begin
            @(posedge clk);
            w++;
            #1;
        end
        if (exp > 0) chk("pulse", pwdt_pkg::RESET_PULSE_CYCLES, w);
        @(posedge clk);
        idle_mode <= 1'b0;
        power_down <= 1'b0;
    endtask
    // flag survives the pulse, software clears it, system reset clears the rest
    task automatic after_fire(input logic [7:0] ctl);
        rd(pwdt_pkg::ADDR_CONTROL, ctl);
        wr(pwdt_pkg::ADDR_CONTROL, ctl & 8'hf0);
        rd(pwdt_pkg::ADDR_CONTROL, ctl & 8'hf0);
        rst();
        rd(pwdt_pkg::ADDR_CONTROL, 8'h00);
    endtask
    task automatic timed(input logic [7:0] ctl, input int pre, input int idl, input int pdl,
        input int exp);
        wr(pwdt_pkg::ADDR_CONTROL, ctl);
        key();
        if (pre > 0) begin
            repeat (pre) @(posedge clk);
            key();
        end
        fire(idl, pdl, exp);
        after_fire((ctl & 8'hf0) | 8'h02);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(pwdt_pkg::ADDR_CONTROL, pwdt_pkg::CONTROL_RESET);
        rd(pwdt_pkg::ADDR_RESTART, 8'h00);
        rd(8'h55, 8'h00);
        wr(pwdt_pkg::ADDR_CONTROL, 8'hfd);
        rd(pwdt_pkg::ADDR_CONTROL, 8'hf0);
        wr(pwdt_pkg::ADDR_CONTROL, 8'h00);
        wr(pwdt_pkg::ADDR_RESTART, pwdt_pkg::KEY_FIRST);
        rd(pwdt_pkg::ADDR_CONTROL, 8'h00);
        wr(pwdt_pkg::ADDR_RESTART, pwdt_pkg::KEY_SECOND);
        rd(pwdt_pkg::ADDR_CONTROL, 8'h01);
        rst();
        rd(pwdt_pkg::ADDR_CONTROL, 8'h00);
        for (int ps = 0; ps < 8; ps++) begin
            timed(8'(ps << 5), 0, 0, 0, 16 << ps);
        end
        timed(8'h00, 10, 0, 0, 16);
        timed(8'h10, 0, 40, 0, 56);
        timed(8'h00, 0, 40, 0, 16);
        timed(8'h00, 0, 0, 40, 56);
        wr(pwdt_pkg::ADDR_RESTART, pwdt_pkg::KEY_FIRST);
        wr(pwdt_pkg::ADDR_RESTART, 8'h55);
        fire(0, 0, 0);
        after_fire(8'h02);
        wr(pwdt_pkg::ADDR_RESTART, pwdt_pkg::KEY_FIRST);
        wr(pwdt_pkg::ADDR_CONTROL, 8'h00);
        fire(0, 0, 0);
        after_fire(8'h02);
        wr(pwdt_pkg::ADDR_RESTART, 8'h5a);
        fire(0, 0, 0);
        after_fire(8'h02);
        test_done();
    end
    // hang guard
    initial begin
        #(40 * 20000);
        miscompares++;
        test_done();
    end
endmodule
